// ### hdl/pipelined_burst_sram_port.sv
// Overview of operation
// RQ1 - Address sampled only with a strobe low and all three selects active.
// RQ2 - Low two address bits of a new address load the burst counter.
// RQ3 - Each low lane select writes its lane only with byte write gate low.
// RQ4 - Global write low writes every lane, ignoring lane selects and gate.
// RQ5 - Controller drives gate low with lane selects for byte writes.
// RQ6 - Burst step low during a burst advances the held burst address.
// RQ7 - Selected only when select_low_a low, select_high high, select_low_b low.
// RQ8 - Processor strobe ignored entirely while select_low_a is high.
// RQ9 - Selects only evaluated on new address loads, not during burst advances.
// RQ10 - Without third select, behave as if it is always active.
// RQ11 - Output enable low drives data and parity, high tri-states them.
// RQ12 - First clock of read after deselect keeps outputs tri-stated.
// RQ13 - Strobe low with device selected captures the address on that edge.
// RQ14 - Both strobes low: act on processor strobe only.
// RQ15 - Sleep request high quiets the device, retaining contents.
// RQ16 - Write data captured from data and parity pins on the rising edge.
// RQ17 - Reads drive contents of the location addressed for that cycle.
// RQ18 - Order strap low gives linear bursts, high or floating interleaved.
// RQ19 - Burst counter wraps within four addresses from the first.
// RQ20 - Read data appears on the edge after address capture.
// RQ21 - New access without any write signal low is a read.
`include "sram_port_regs.svh"

module pipelined_burst_sram_port #(
    parameter int ADDR_W = `SRAM_ADDR_BITS, // Word address width
    parameter bit HAS_SEL3 = 1'b1 // Package carries third select
) (
    input wire logic mclk, // Clock, 10 MHz
    input wire logic nrst, // Async reset, active low
    input wire logic [ADDR_W-1:0] addr, // Word address
    input wire sram_port_pkg::bus_ctrl_t ctrl, // Synchronous control pins
    input wire logic output_enable_n, // Async output enable pin
    input wire logic sleep_request, // Async sleep pin
    input wire logic burst_order, // Order strap, low for linear
    input wire logic [31:0] data_in, // Data pins, input side
    input wire logic [`SRAM_LANES-1:0] parity_in, // Parity pins, input side
    output logic [31:0] data_out, // Data pins, output side
    output logic [`SRAM_LANES-1:0] parity_out, // Parity pins, output side
    output logic data_oe_n, // Data pins driven when low
    output logic parity_oe_n, // Parity pins driven when low
    output logic sleeping // Sleep condition entered
);
    localparam int WORD_W = `SRAM_LANES * (`SRAM_LANE_BITS + 1);
    localparam int DEPTH = 2 ** ADDR_W;

    // Storage, one word per location, lane i at i*9 with parity on top
    logic [WORD_W-1:0] mem [DEPTH];

    // Synchronisers for the asynchronous pins
    logic oe_meta;
    logic oe_n_s;
    logic zz_meta;
    logic zz_s;
    logic strap_meta;
    logic strap_s;

    // Strap capture
    logic [1:0] settle;
    logic [1:0] next_settle;
    logic interleave;
    logic next_interleave;

    // Access state
    sram_port_pkg::access_t state;
    sram_port_pkg::access_t next_state;
    logic [ADDR_W-1:`SRAM_CNT_BITS] addr_hi;
    logic [ADDR_W-1:`SRAM_CNT_BITS] next_addr_hi;
    logic [`SRAM_CNT_BITS-1:0] burst_low_bits;
    logic [ADDR_W-1:0] cur_addr;

    // Edge decisions
    logic cpu_go;
    logic ctl_go;
    logic start;
    logic sel_ok;
    logic load;
    logic step;
    logic deselect_now;
    logic [`SRAM_LANES-1:0] lanes;
    logic [`SRAM_LANES-1:0] wr_lanes;
    logic [ADDR_W-1:0] wr_addr;
    logic rd_now;
    logic [WORD_W-1:0] cur_word;
    logic [WORD_W-1:0] pin_word;

    // Output registers
    logic [31:0] next_data_out;
    logic [`SRAM_LANES-1:0] next_parity_out;
    logic next_drive;

    // Device selected from the three selects; missing third one counts active
    function automatic logic selected(input sram_port_pkg::bus_ctrl_t c);
        selected = !c.select_low_a && c.select_high
            && (!HAS_SEL3 || !c.select_low_b); // RQ7 RQ10
    endfunction : selected

    // Lanes to write: global write overrides, else gate qualifies selects
    function automatic logic [`SRAM_LANES-1:0] write_lanes(input sram_port_pkg::bus_ctrl_t c);
        if (!c.global_write_n) begin
            write_lanes = `SRAM_ALL_LANES; // RQ4
        end else if (!c.byte_write_gate_n) begin
            write_lanes = ~c.byte_lane_select_n; // RQ3
        end else begin
            write_lanes = `SRAM_NO_LANES;
        end
    endfunction : write_lanes

    // Two flip-flops on each asynchronous pin
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oe_meta <= 1'b1;
            oe_n_s <= 1'b1;
            zz_meta <= 1'b0;
            zz_s <= 1'b0;
            strap_meta <= 1'b1;
            strap_s <= 1'b1;
        end else begin
            oe_meta <= output_enable_n;
            oe_n_s <= oe_meta;
            zz_meta <= sleep_request;
            zz_s <= zz_meta;
            strap_meta <= burst_order;
            strap_s <= strap_meta;
        end
    end

    // Order strap is taken once the synchroniser has filled after reset
    always_comb begin
        next_settle = settle;
        next_interleave = interleave;
        if (settle != `SRAM_STRAP_SETTLE) begin
            next_settle = settle + 2'h1;
        end else begin
            next_interleave = strap_s; // RQ18
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            settle <= 2'h0;
            interleave <= 1'b1;
        end else begin
            settle <= next_settle;
            interleave <= next_interleave;
        end
    end

    // Strobe decode: processor strobe needs select_low_a low and wins a tie
    always_comb begin
        sel_ok = selected(ctrl);
        cpu_go = !ctrl.cpu_addr_strobe_n && !ctrl.select_low_a; // RQ8
        ctl_go = !ctrl.ctl_addr_strobe_n && !cpu_go; // RQ14
        start = (cpu_go || ctl_go) && !zz_s;
        load = start && sel_ok; // RQ1 RQ13
        deselect_now = start && !sel_ok;
        lanes = write_lanes(ctrl);
    end

    // Burst counter holds the low address bits
    burst_counter u_burst (
        .mclk(mclk),
        .nrst(nrst),
        .load(load),
        .step(step),
        .interleave(interleave),
        .first_in(addr[`SRAM_CNT_BITS-1:0]),
        .burst_low_bits(burst_low_bits)
    );

    assign cur_addr = {addr_hi, burst_low_bits};
    assign cur_word = mem[cur_addr];

    // Next access state and write decision for this edge
    always_comb begin
        next_state = state;
        next_addr_hi = addr_hi;
        step = 1'b0;
        wr_lanes = `SRAM_NO_LANES;
        wr_addr = cur_addr;
        if (zz_s) begin
            next_state = sram_port_pkg::ACC_SLEEP; // RQ15
        end else if (start) begin
            if (sel_ok) begin
                next_addr_hi = addr[ADDR_W-1:`SRAM_CNT_BITS]; // RQ13
                if (cpu_go || lanes == `SRAM_NO_LANES) begin
                    next_state = sram_port_pkg::ACC_READ; // RQ21
                end else begin
                    next_state = sram_port_pkg::ACC_WRITE;
                    wr_lanes = lanes;
                    wr_addr = addr;
                end
            end else begin
                next_state = sram_port_pkg::ACC_IDLE;
            end
        end else if (state == sram_port_pkg::ACC_READ || state == sram_port_pkg::ACC_WRITE) begin
            // Selects are not looked at here
            wr_lanes = lanes; // RQ9
            step = !ctrl.burst_step_n; // RQ6
            if (lanes != `SRAM_NO_LANES) begin
                next_state = sram_port_pkg::ACC_WRITE;
            end
        end else if (state == sram_port_pkg::ACC_SLEEP) begin
            next_state = sram_port_pkg::ACC_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= sram_port_pkg::ACC_IDLE;
            addr_hi <= '0;
        end else begin
            state <= next_state;
            addr_hi <= next_addr_hi;
        end
    end

    // Pin lanes gathered into the stored word layout
    generate
        for (genvar i = 0; i < `SRAM_LANES; i++) begin : g_lane
            assign pin_word[i*9 +: 9] = {parity_in[i], data_in[i*8 +: 8]};
        end
    endgenerate

    // Lane write straight from the pins; one process owns the whole array
    always_ff @(posedge mclk) begin
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (wr_lanes[i]) begin
                mem[wr_addr][i*9 +: 9] <= pin_word[i*9 +: 9]; // RQ16
            end
        end
    end

    // Read out of the current location; nothing drives from idle, so a read
    // starting from deselect stays tri-stated in its first clock
    always_comb begin
        rd_now = state == sram_port_pkg::ACC_READ && !zz_s
            && wr_lanes == `SRAM_NO_LANES && !start; // RQ12
        if (state == sram_port_pkg::ACC_READ && !zz_s && !deselect_now) begin
            rd_now = wr_lanes == `SRAM_NO_LANES || start;
        end
        next_data_out = data_out;
        next_parity_out = parity_out;
        for (int i = 0; i < `SRAM_LANES; i++) begin
            if (rd_now) begin
                next_data_out[i*8 +: 8] = cur_word[i*9 +: 8]; // RQ17 RQ20
                next_parity_out[i] = cur_word[i*9 + 8];
            end
        end
        next_drive = rd_now && !oe_n_s; // RQ11
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            data_out <= `SRAM_DOUT_RST;
            parity_out <= `SRAM_POUT_RST;
            data_oe_n <= 1'b1;
            parity_oe_n <= 1'b1;
            sleeping <= 1'b0;
        end else begin
            data_out <= next_data_out;
            parity_out <= next_parity_out;
            data_oe_n <= !next_drive; // RQ11
            parity_oe_n <= !next_drive;
            sleeping <= zz_s; // RQ15
        end
    end

    // Checks
    a_cpu_strobe_ignored: assert property (@(posedge mclk) disable iff (!nrst) // RQ8
        (!ctrl.cpu_addr_strobe_n && ctrl.select_low_a && ctrl.ctl_addr_strobe_n && !zz_s)
            |=> addr_hi == $past(addr_hi)
            && ($past(state) != sram_port_pkg::ACC_IDLE || state == sram_port_pkg::ACC_IDLE))
        else $error("processor strobe acted with select_low_a high");

    a_addr_captured: assert property (@(posedge mclk) disable iff (!nrst) // RQ1
        (start && sel_ok) |=> cur_addr == $past(addr))
        else $error("address not captured on selected strobe");

    a_burst_first: assert property (@(posedge mclk) disable iff (!nrst) // RQ2
        load |=> burst_low_bits == $past(addr[`SRAM_CNT_BITS-1:0]))
        else $error("burst counter not loaded from low address bits");

    a_deselect_tristate: assert property (@(posedge mclk) disable iff (!nrst) // RQ7
        (start && !sel_ok) |=> data_oe_n && state == sram_port_pkg::ACC_IDLE)
        else $error("deselect did not tri-state outputs");

    a_first_read_quiet: assert property (@(posedge mclk) disable iff (!nrst) // RQ12
        (state == sram_port_pkg::ACC_IDLE && load) |=> data_oe_n)
        else $error("outputs driven in first read clock after deselect");

    a_both_strobes_cpu: assert property (@(posedge mclk) disable iff (!nrst) // RQ14
        (!ctrl.cpu_addr_strobe_n && !ctrl.ctl_addr_strobe_n && sel_ok && !zz_s && !ctrl.global_write_n)
            |=> state == sram_port_pkg::ACC_READ)
        else $error("controller strobe acted alongside processor strobe");

    a_burst_wraps: assert property (@(posedge mclk) disable iff (!nrst) // RQ19
        (step && !interleave) |=> burst_low_bits == $past(burst_low_bits) + 2'h1)
        else $error("linear burst step wrong");

    a_burst_ignores_sel: assert property (@(posedge mclk) disable iff (!nrst) // RQ9
        (state == sram_port_pkg::ACC_READ && !start && !zz_s && !ctrl.select_high
            && lanes == `SRAM_NO_LANES) |=> state == sram_port_pkg::ACC_READ)
        else $error("selects acted during a burst cycle");

    a_global_write: assert property (@(posedge mclk) disable iff (!nrst) // RQ4
        (!ctrl.global_write_n && !start && !zz_s && state == sram_port_pkg::ACC_WRITE)
            |=> mem[$past(cur_addr)] == $past(pin_word))
        else $error("global write did not fill every lane");

    a_gate_high_no_write: assert property (@(posedge mclk) disable iff (!nrst) // RQ3
        (ctrl.global_write_n && ctrl.byte_write_gate_n) |-> wr_lanes == `SRAM_NO_LANES)
        else $error("write without gate or global write");

    a_read_data: assert property (@(posedge mclk) disable iff (!nrst) // RQ20
        rd_now |=> data_out == {$past(cur_word[34:27]), $past(cur_word[25:18]),
            $past(cur_word[16:9]), $past(cur_word[7:0])}
            && parity_out == {$past(cur_word[35]), $past(cur_word[26]), $past(cur_word[17]), $past(cur_word[8])})
        else $error("read data not from addressed location");

    a_oe_high_quiet: assert property (@(posedge mclk) disable iff (!nrst) // RQ11
        oe_n_s |=> data_oe_n && parity_oe_n)
        else $error("pins driven with output enable high");

    a_sleep_quiet: assert property (@(posedge mclk) disable iff (!nrst) // RQ15
        zz_s |-> (wr_lanes == `SRAM_NO_LANES) ##1 data_oe_n)
        else $error("activity while asleep");

    a_read_default: assert property (@(posedge mclk) disable iff (!nrst) // RQ21
        (load && ctrl.global_write_n && ctrl.byte_write_gate_n) |=> state == sram_port_pkg::ACC_READ)
        else $error("access without write signals not treated as read");

    a_write_lands: assert property (@(posedge mclk) disable iff (!nrst) // RQ16
        (wr_lanes == `SRAM_ALL_LANES) |=> mem[$past(wr_addr)] == $past(pin_word))
        else $error("pin data not stored on full write");

    c_burst_four: cover property (@(posedge mclk) disable iff (!nrst)
        load ##1 step [*3]);
    c_global_write: cover property (@(posedge mclk) disable iff (!nrst)
        state == sram_port_pkg::ACC_WRITE && !ctrl.global_write_n);
    c_read_driven: cover property (@(posedge mclk) disable iff (!nrst)
        load ##2 !data_oe_n);
    c_sleep: cover property (@(posedge mclk) disable iff (!nrst)
        sleeping ##1 !sleeping);
    c_cpu_write: cover property (@(posedge mclk) disable iff (!nrst)
        (load && cpu_go) ##1 (wr_lanes != `SRAM_NO_LANES));

endmodule : pipelined_burst_sram_port

// ### hdl/sram_port_regs.svh
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// Geometry of one stored word: four lanes of eight data bits plus one parity bit
`define SRAM_LANES 4
`define SRAM_LANE_BITS 8
`define SRAM_ADDR_BITS 20
`define SRAM_CNT_BITS 2

// Lane write patterns
`define SRAM_ALL_LANES 4'hF
`define SRAM_NO_LANES 4'h0

// Reset values of the output registers and the burst counter
`define SRAM_DOUT_RST 32'h0000_0000
`define SRAM_POUT_RST 4'h0
`define SRAM_CNT_RST 2'h0

// Strap settling: edges after reset release before the order pin is taken
`define SRAM_STRAP_SETTLE 2'h2

`endif

// ### hdl/sram_port_pkg.sv
`include "sram_port_regs.svh"

package sram_port_pkg;

    // Access pipeline state, Gray coded along idle, read, write
    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_READ = 2'b01,
        ACC_WRITE = 2'b11,
        ACC_SLEEP = 2'b10
    } access_t;

    // Synchronous control pins, sampled on the rising clock edge
    typedef struct packed {
        logic cpu_addr_strobe_n;
        logic ctl_addr_strobe_n;
        logic burst_step_n;
        logic global_write_n;
        logic byte_write_gate_n;
        logic [`SRAM_LANES-1:0] byte_lane_select_n;
        logic select_low_a;
        logic select_high;
        logic select_low_b;
    } bus_ctrl_t;

endpackage : sram_port_pkg

// ### hdl/burst_counter.sv
`include "sram_port_regs.svh"

module burst_counter (
    input wire logic mclk, // Clock
    input wire logic nrst, // Async reset, active low
    input wire logic load, // Take a new first address
    input wire logic step, // Advance to next burst address
    input wire logic interleave, // High for interleaved order
    input wire logic [`SRAM_CNT_BITS-1:0] first_in, // Low address bits to load
    output logic [`SRAM_CNT_BITS-1:0] burst_low_bits // Current low address bits
);
    logic [`SRAM_CNT_BITS-1:0] first;
    logic [`SRAM_CNT_BITS-1:0] offset;
    logic [`SRAM_CNT_BITS-1:0] next_first;
    logic [`SRAM_CNT_BITS-1:0] next_offset;

    // Load on a new address, otherwise step; two-bit offset wraps in four
    always_comb begin
        next_first = first;
        next_offset = offset;
        if (load) begin
            next_first = first_in; // RQ2
            next_offset = `SRAM_CNT_RST;
        end else if (step) begin
            next_offset = offset + 2'h1; // RQ19
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            first <= `SRAM_CNT_RST;
            offset <= `SRAM_CNT_RST;
        end else begin
            first <= next_first;
            offset <= next_offset;
        end
    end

    // Interleaved order flips bits of the first address, linear adds
    always_comb begin
        if (interleave) begin
            burst_low_bits = first ^ offset; // RQ18
        end else begin
            burst_low_bits = first + offset; // RQ19
        end
    end

endmodule : burst_counter

// ### test/ctl_bus_model.sv
// Controller side of the shared data and parity wires
module ctl_bus_model (
    input wire logic mclk, // Clock
    input wire logic drive_en, // Controller drives the pins
    input wire logic [35:0] wr_word, // Parity and data to drive
    input wire logic [31:0] data_out, // Device data
    input wire logic [3:0] parity_out, // Device parity
    input wire logic dev_oe_n, // Device drives when low
    output logic [31:0] data_in, // Resolved data wire
    output logic [3:0] parity_in // Resolved parity wire
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [35:0] last = 36'h0_0000_0000;
    logic [35:0] pins;

    // Wire level; no pull, so a floating wire flips every cycle
    always_comb begin
        if (drive_en) begin
            pins = wr_word;
        end else if (!dev_oe_n) begin
            pins = {parity_out, data_out};
        end else begin
            pins = ~last;
        end
    end

    // Remember the last level for the floating case
    always_ff @(posedge mclk) begin
        last <= pins;
    end

    assign data_in = pins[31:0];
    assign parity_in = pins[35:32];
endmodule : ctl_bus_model

// ### test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 6;
    localparam logic [4:0] k_idle = 5'h1F;
    localparam logic [4:0] k_cpu = 5'h0F;
    localparam logic [4:0] k_ctl = 5'h17;
    localparam logic [4:0] k_step = 5'h1B;
    localparam logic [4:0] k_gw = 5'h1D;
    localparam logic [4:0] k_bwe = 5'h1E;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [AW-1:0] addr = 6'h00;
    sram_port_pkg::bus_ctrl_t ctrl = 12'hFFA;
    logic oe_pin_n = 1'b0;
    logic sleep_request = 1'b0;
    logic burst_order = 1'b0;
    logic drive_en = 1'b0;
    logic [35:0] wr_word = 36'h0_0000_0000;
    logic [31:0] data_in, data_out, data_out2;
    logic [3:0] parity_in, parity_out, parity_out2;
    logic data_oe_n, parity_oe_n, oe2_n, sleeping;
    logic [35:0] mem_ref [64];
    logic [31:0] seed = 32'h3609_5841;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    // Device under test and a variant without the third select
    pipelined_burst_sram_port #(.ADDR_W(AW), .HAS_SEL3(1'b1)) pipelined_burst_sram_port_inst (
        .mclk(mclk), .nrst(nrst), .addr(addr), .ctrl(ctrl), .output_enable_n(oe_pin_n),
        .sleep_request(sleep_request), .burst_order(burst_order), .data_in(data_in),
        .parity_in(parity_in), .data_out(data_out), .parity_out(parity_out),
        .data_oe_n(data_oe_n), .parity_oe_n(parity_oe_n), .sleeping(sleeping));
    pipelined_burst_sram_port #(.ADDR_W(AW), .HAS_SEL3(1'b0)) pipelined_burst_sram_port_inst2 (
        .mclk(mclk), .nrst(nrst), .addr(addr), .ctrl(ctrl), .output_enable_n(oe_pin_n),
        .sleep_request(sleep_request), .burst_order(burst_order), .data_in(data_in),
        .parity_in(parity_in), .data_out(data_out2), .parity_out(parity_out2),
        .data_oe_n(oe2_n), .parity_oe_n(), .sleeping());
    ctl_bus_model ctl_bus_model_inst (
        .mclk(mclk), .drive_en(drive_en), .wr_word(wr_word), .data_out(data_out),
        .parity_out(parity_out), .dev_oe_n(data_oe_n), .data_in(data_in), .parity_in(parity_in));

    // Clock and hang guard
    initial begin
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles++;
        if (cycles > 3000) begin
            fails++;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // Low address bits of beat k
    function automatic logic [1:0] beat(input logic [1:0] a, input logic [1:0] k, input logic il);
        return il ? (a ^ k) : (a + k);
    endfunction : beat

    // Word after a byte write with active-low lane selects
    function automatic logic [35:0] merge(input logic [35:0] old, input logic [35:0] nw, input logic [3:0] sel_n);
        logic [35:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (!sel_n[i]) begin
                res[8*i+:8] = nw[8*i+:8];
                res[32+i] = nw[32+i];
            end
        end
        return res;
    endfunction : merge

    task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // One bus cycle, driven at the falling edge
    task automatic go(input logic [4:0] f, input logic [3:0] ln, input logic [2:0] sel,
                      input logic [AW-1:0] a, input logic [35:0] w, input logic drv);
        @(negedge mclk);
        ctrl = {f, ln, sel};
        addr = a;
        wr_word = w;
        drive_en = drv;
    endtask : go

    task automatic nop();
        go(k_idle, 4'hF, 3'h2, addr, wr_word, 1'b0);
    endtask : nop

    // Start a read and wait for its data
    task automatic rd(input logic [4:0] f, input logic [AW-1:0] a);
        go(f, 4'hF, 3'h2, a, wr_word, 1'b0);
        nop();
        nop();
    endtask : rd

    // Four-beat burst plus wrap; selects dropped while advancing
    task automatic burst_rd(input logic [AW-1:0] a, input logic [4:0] f);
        go(f, 4'hF, 3'h2, a, wr_word, 1'b0);
        go(k_step, 4'hF, 3'h0, a, wr_word, 1'b0);
        for (int k = 0; k < 5; k++) begin
            go(k_step, 4'hF, 3'h0, a, wr_word, 1'b0);
            chk({parity_out, data_out}, mem_ref[{a[AW-1:2], beat(a[1:0], 2'(k), burst_order)}], "burst");
        end
        nop();
    endtask : burst_rd

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    initial begin
        logic [35:0] w;
        logic [31:0] r;
        logic [AW-1:0] a;
        logic [3:0] ln;
        for (int il = 0; il < 2; il++) begin
            nrst = 1'b0;
            burst_order = il[0];
            repeat (5) @(negedge mclk);
            nrst = 1'b1;
            repeat (3) @(negedge mclk);
            // Fill all words with global writes, lane inputs random
            for (int i = 0; i < 64 && il == 0; i++) begin
                r = rnd();
                w = {r[3:0], rnd()};
                go(k_ctl & k_gw & (r[4] ? k_bwe : k_idle), r[8:5], 3'h2, 6'(i), w, 1'b1);
                mem_ref[i] = w;
            end
            repeat (4) begin
                r = rnd();
                burst_rd(r[AW-1:0], r[8] ? k_cpu : k_ctl);
            end
        end
        // Byte writes with random lane selects
        repeat (8) begin
            r = rnd();
            a = r[AW-1:0];
            ln = r[11:8];
            w = {r[15:12], rnd()};
            go(k_ctl & k_bwe, ln, 3'h2, a, w, 1'b1);
            mem_ref[a] = merge(mem_ref[a], w, ln);
        end
        // Lane selects without gate, then both strobes with global write: reads only
        a = 6'(rnd());
        go(k_ctl, 4'h0, 3'h2, a, wr_word, 1'b0);
        nop();
        nop();
        chk({parity_out, data_out}, mem_ref[a], "lanes without gate");
        go(k_cpu & k_ctl & k_gw, 4'h0, 3'h2, a, ~mem_ref[a], 1'b1);
        nop();
        nop();
        chk({parity_out, data_out}, mem_ref[a], "both strobes");
        // Processor strobe while first select is high
        go(k_cpu, 4'hF, 3'h6, ~a, wr_word, 1'b0);
        nop();
        nop();
        chk({parity_out, data_out}, mem_ref[a], "ignored strobe data");
        chk(36'(data_oe_n), 36'(1'b0), "ignored strobe drive");
        // Each deselect pattern, then a read emerging from it
        for (int j = 0; j < 3; j++) begin
            go(k_ctl, 4'hF, (j == 0) ? 3'h6 : (j == 1) ? 3'h0 : 3'h3, a, wr_word, 1'b0);
            nop();
            nop();
            chk(36'(data_oe_n), 36'(1'b1), "deselect");
            a = 6'(rnd());
            go(k_ctl, 4'hF, 3'h2, a, wr_word, 1'b0);
            nop();
            chk(36'(data_oe_n), 36'(1'b1), "first cycle mask");
            nop();
            chk(36'(data_oe_n), 36'(1'b0), "drive after mask");
            chk({parity_out, data_out}, mem_ref[a], "read after deselect");
        end
        // Third select high: only the variant without it answers
        go(k_ctl, 4'hF, 3'h3, a ^ 6'h15, wr_word, 1'b0);
        nop();
        nop();
        chk({parity_out2, data_out2}, mem_ref[a ^ 6'h15], "no third select");
        chk(36'(oe2_n), 36'(1'b0), "no third select drive");
        chk(36'(data_oe_n), 36'(1'b1), "third select high");
        // Output enable high keeps pins released
        oe_pin_n = 1'b1;
        rd(k_cpu, a);
        nop();
        chk(36'(data_oe_n), 36'(1'b1), "oe high");
        chk({parity_out, data_out}, mem_ref[a], "oe high data");
        oe_pin_n = 1'b0;
        repeat (3) nop();
        chk(36'(data_oe_n), 36'(1'b0), "oe low");
        chk(36'(parity_oe_n), 36'(1'b0), "parity drive");
        // Sleep: no writes, contents kept
        sleep_request = 1'b1;
        repeat (3) nop();
        chk(36'(sleeping), 36'(1'b1), "sleep entry");
        chk(36'(data_oe_n), 36'(1'b1), "sleep drive");
        go(k_ctl & k_gw, 4'hF, 3'h2, a, ~mem_ref[a], 1'b1);
        nop();
        sleep_request = 1'b0;
        repeat (4) nop();
        chk(36'(sleeping), 36'(1'b0), "sleep exit");
        // Processor-started write: global write data follows in the burst beats
        r = rnd();
        a = r[AW-1:0];
        go(k_cpu, 4'hF, 3'h2, a, wr_word, 1'b0);
        for (int k = 0; k < 2; k++) begin
            w = {r[11:8], rnd()};
            go(k_gw & k_step, 4'hF, 3'h0, a, w, 1'b1);
            mem_ref[{a[AW-1:2], beat(a[1:0], 2'(k), burst_order)}] = w;
        end
        nop();
        // Sweep of every word
        for (int i = 0; i < 64; i++) begin
            rd(k_ctl, 6'(i));
            chk({parity_out, data_out}, mem_ref[i], "sweep");
        end
        stop_test();
    end
endmodule : tb_top
